// ==== logic/bsr_pkg.sv ====
package bsr_pkg;
	typedef enum logic [1:0] {
		BSR_ST_SAMPLE = 2'b00,
		BSR_ST_HOLD = 2'b01,
		BSR_ST_RUN = 2'b10
	} bsr_state_t;
	typedef enum logic [1:0] {
		BSR_MS_RSVD = 2'b00,
		BSR_MS_SYNC_RST = 2'b01,
		BSR_MS_ENABLE = 2'b11
	} bsr_mod_state_t;
endpackage : bsr_pkg

// ==== logic/bsr_regs.svh ====
`ifndef BSR_REGS_SVH
`define BSR_REGS_SVH
`define BSR_BOOT_ROM_NAND 2'h0
`define BSR_BOOT_EXT_MEM 2'h1
`define BSR_BOOT_ROM_MMC 2'h2
`define BSR_BOOT_ROM_UART 2'h3
`define BSR_ROM_VECTOR 32'h00008000
`define BSR_EXT_VECTOR 32'h02000000
`define BSR_SETUP_RST 5'h10
`define BSR_STROBE_RST 7'h40
`define BSR_HOLD_RST 4'h8
`define BSR_NUM_MODULES 41
`define BSR_MOD_DMA_CHAN 2
`define BSR_MOD_DMA_TC_A 3
`define BSR_MOD_DMA_TC_B 4
`define BSR_MOD_EXT_MEM 14
`define BSR_MOD_MMC0 15
`define BSR_MOD_UART0 19
`define BSR_MOD_SPI0 22
`define BSR_MOD_TIMER0 27
`define BSR_MOD_ENA_FIRST 29
`define BSR_MOD_ENA_LAST 38
`define BSR_MOD_RSVD_A 16
`define BSR_MOD_RSVD_B 39
`define BSR_SAMPLE_CYCLES 3'h3
`endif

// ==== logic/bsr_sync2.sv ====
`timescale 1ns/1ns
module bsr_sync2 (
	input wire logic CLK, // Clock.
	input wire logic SYS_RST, // Synchronous reset.
	input wire logic [5:0] d, // Asynchronous input bits.
	output logic [5:0] q // Synchronised bits.
);
	logic [5:0] meta_ff;
	logic [5:0] q_ff;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			meta_ff <= 6'h00;
			q_ff <= 6'h00;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end
	assign q = q_ff;
endmodule : bsr_sync2

// ==== logic/bsr_top.sv ====
`timescale 1ns/1ns
`include "bsr_regs.svh"
module bsr_top (
	input wire logic CLK, // Reference clock.
	input wire logic SYS_RST, // Power-on, warm or max reset.
	input wire logic [1:0] BOOT_SELECT_PINS, // Boot-select straps.
	input wire logic [3:0] EXT_MEM_PIN_CONFIG_STRAPS, // Memory pin-config straps.
	input wire logic TIMING_WR, // Software timing write strobe.
	input wire logic [4:0] TIMING_SETUP_IN, // New setup cycles.
	input wire logic [6:0] TIMING_STROBE_IN, // New strobe cycles.
	input wire logic [3:0] TIMING_HOLD_IN, // New hold cycles.
	output logic [81:0] MODULE_STATE, // Two bits per module.
	output logic [40:0] MODULE_POWER_ON, // Power domain on per module.
	output logic [31:0] BOOT_VECTOR, // First-fetch jump target.
	output logic BOOT_FROM_EXT_MEM, // Fetch from external window.
	output logic [1:0] BOOT_CONFIG_REGISTER, // Sampled boot code.
	output logic [3:0] EXT_MEM_PIN_CONFIG, // Sampled pin config.
	output logic STRAPS_RELEASED, // Shared pins act as memory pins.
	output logic CONFIG_VALID, // Defaults applied, boot may start.
	output logic [4:0] TIMING_SETUP, // Setup cycles.
	output logic [6:0] TIMING_STROBE, // Strobe cycles.
	output logic [3:0] TIMING_HOLD // Hold cycles.
);
	logic [5:0] straps_sync;
	bsr_sync2 i_bsr_sync2 (
		.CLK(CLK),
		.SYS_RST(SYS_RST),
		.d({BOOT_SELECT_PINS, EXT_MEM_PIN_CONFIG_STRAPS}),
		.q(straps_sync)
	);

	bsr_pkg::bsr_state_t state_ff, nxt_state;
	logic [2:0] cnt_ff, nxt_cnt;
	logic [1:0] boot_sel_ff, nxt_boot_sel;
	logic [3:0] pin_cfg_ff, nxt_pin_cfg;

	// Straps are sampled only after the synchroniser has filled, then frozen.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_boot_sel = boot_sel_ff;
		nxt_pin_cfg = pin_cfg_ff;
		case (state_ff)
			bsr_pkg::BSR_ST_SAMPLE: begin
				nxt_cnt = cnt_ff + 3'h1;
				if (cnt_ff == `BSR_SAMPLE_CYCLES) begin
					nxt_boot_sel = straps_sync[5:4];
					nxt_pin_cfg = straps_sync[3:0];
					nxt_state = bsr_pkg::BSR_ST_HOLD;
				end
			end
			bsr_pkg::BSR_ST_HOLD: nxt_state = bsr_pkg::BSR_ST_RUN;
			bsr_pkg::BSR_ST_RUN: nxt_state = bsr_pkg::BSR_ST_RUN;
			default: nxt_state = bsr_pkg::BSR_ST_SAMPLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_ff <= bsr_pkg::BSR_ST_SAMPLE;
			cnt_ff <= 3'h0;
			boot_sel_ff <= 2'h0;
			pin_cfg_ff <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			boot_sel_ff <= nxt_boot_sel;
			pin_cfg_ff <= nxt_pin_cfg;
		end
	end

	logic sampled;
	assign sampled = (state_ff != bsr_pkg::BSR_ST_SAMPLE);

	// Module state table, derived from the frozen boot code.
	wire logic [81:0] nxt_mod;
	logic [81:0] mod_ff;
	logic ext_boot;
	logic mem_if_on;
	assign ext_boot = (boot_sel_ff == `BSR_BOOT_EXT_MEM);
	assign mem_if_on = (boot_sel_ff != `BSR_BOOT_ROM_MMC);

	genvar gi;
	generate
		for (gi = 0; gi < `BSR_NUM_MODULES; gi++) begin : g_mod
			// Each entry computes its own two bits so that no process shares a driven variable.
			logic [1:0] nxt_ms;
			always_comb begin
				logic on;
				on = 1'b0;
				if (gi == `BSR_MOD_DMA_CHAN || gi == `BSR_MOD_DMA_TC_A || gi == `BSR_MOD_DMA_TC_B
					|| gi == `BSR_MOD_EXT_MEM) begin
					on = mem_if_on;
				end else if (gi == `BSR_MOD_MMC0) begin
					on = (boot_sel_ff == `BSR_BOOT_ROM_MMC);
				end else if (gi == `BSR_MOD_UART0) begin
					on = (boot_sel_ff == `BSR_BOOT_ROM_UART);
				end else if (gi == `BSR_MOD_SPI0) begin
					on = !ext_boot;
				end else if (gi == `BSR_MOD_TIMER0) begin
					on = 1'b1;
				end else if (gi >= `BSR_MOD_ENA_FIRST && gi <= `BSR_MOD_ENA_LAST) begin
					on = 1'b1;
				end
				if (gi == `BSR_MOD_RSVD_A || gi == `BSR_MOD_RSVD_B) begin
					nxt_ms = bsr_pkg::BSR_MS_RSVD;
				end else if (!sampled) begin
					nxt_ms = bsr_pkg::BSR_MS_SYNC_RST;
				end else begin
					nxt_ms = on ? bsr_pkg::BSR_MS_ENABLE : bsr_pkg::BSR_MS_SYNC_RST;
				end
			end
			assign nxt_mod[2*gi +: 2] = nxt_ms;
			assign MODULE_POWER_ON[gi] = !(gi == `BSR_MOD_RSVD_A || gi == `BSR_MOD_RSVD_B);
		end
	endgenerate

	// Boot vector and timing registers.
	logic [31:0] nxt_vec, vec_ff;
	logic [4:0] nxt_setup, setup_ff;
	logic [6:0] nxt_strobe, strobe_ff;
	logic [3:0] nxt_hold, hold_ff;

	always_comb begin
		nxt_vec = ext_boot ? `BSR_EXT_VECTOR : `BSR_ROM_VECTOR;
		nxt_setup = setup_ff;
		nxt_strobe = strobe_ff;
		nxt_hold = hold_ff;
		// Only a software write moves the timing off its slowest default.
		if (TIMING_WR && state_ff == bsr_pkg::BSR_ST_RUN) begin
			nxt_setup = TIMING_SETUP_IN;
			nxt_strobe = TIMING_STROBE_IN;
			nxt_hold = TIMING_HOLD_IN;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			mod_ff <= {41{bsr_pkg::BSR_MS_SYNC_RST}};
			vec_ff <= `BSR_ROM_VECTOR;
			setup_ff <= `BSR_SETUP_RST;
			strobe_ff <= `BSR_STROBE_RST;
			hold_ff <= `BSR_HOLD_RST;
		end else begin
			mod_ff <= nxt_mod;
			vec_ff <= nxt_vec;
			setup_ff <= nxt_setup;
			strobe_ff <= nxt_strobe;
			hold_ff <= nxt_hold;
		end
	end

	assign MODULE_STATE = mod_ff;
	assign BOOT_VECTOR = vec_ff;
	// Direct fetch assumes a random-read memory on the first chip select; raw NAND is never fetched here.
	assign BOOT_FROM_EXT_MEM = ext_boot && (state_ff == bsr_pkg::BSR_ST_RUN);
	assign BOOT_CONFIG_REGISTER = boot_sel_ff;
	assign EXT_MEM_PIN_CONFIG = pin_cfg_ff;
	assign STRAPS_RELEASED = sampled;
	assign CONFIG_VALID = (state_ff == bsr_pkg::BSR_ST_RUN);
	assign TIMING_SETUP = setup_ff;
	assign TIMING_STROBE = strobe_ff;
	assign TIMING_HOLD = hold_ff;

	property p_rst_default;
		@(posedge CLK) SYS_RST |=> (TIMING_SETUP == 5'h10 && TIMING_STROBE == 7'h40 && TIMING_HOLD == 4'h8
			&& !CONFIG_VALID);
	endproperty
	a_rst_default: assert property (p_rst_default) else $error("timing not slowest after reset");

	property p_vec;
		@(posedge CLK) disable iff (SYS_RST) CONFIG_VALID |-> BOOT_VECTOR ==
			((BOOT_CONFIG_REGISTER == 2'h1) ? 32'h02000000 : 32'h00008000);
	endproperty
	a_vec: assert property (p_vec) else $error("boot vector mismatch");

	property p_ext_vec;
		@(posedge CLK) disable iff (SYS_RST) BOOT_FROM_EXT_MEM |-> BOOT_VECTOR == 32'h02000000;
	endproperty
	a_ext_vec: assert property (p_ext_vec) else $error("external vector wrong");

	property p_dma;
		@(posedge CLK) disable iff (SYS_RST) CONFIG_VALID |->
			(MODULE_STATE[29:28] == 2'h3) == (BOOT_CONFIG_REGISTER != 2'h2);
	endproperty
	a_dma: assert property (p_dma) else $error("memory interface state wrong");

	property p_mmc;
		@(posedge CLK) disable iff (SYS_RST) CONFIG_VALID |->
			(MODULE_STATE[31:30] == 2'h3) == (BOOT_CONFIG_REGISTER == 2'h2);
	endproperty
	a_mmc: assert property (p_mmc) else $error("card controller state wrong");

	property p_uart;
		@(posedge CLK) disable iff (SYS_RST) CONFIG_VALID |->
			(MODULE_STATE[39:38] == 2'h3) == (BOOT_CONFIG_REGISTER == 2'h3);
	endproperty
	a_uart: assert property (p_uart) else $error("uart state wrong");

	property p_spi;
		@(posedge CLK) disable iff (SYS_RST) CONFIG_VALID |->
			(MODULE_STATE[45:44] == 2'h1) == (BOOT_CONFIG_REGISTER == 2'h1);
	endproperty
	a_spi: assert property (p_spi) else $error("spi state wrong");

	property p_timer;
		@(posedge CLK) disable iff (SYS_RST) CONFIG_VALID |-> MODULE_STATE[55:54] == 2'h3
			&& MODULE_STATE[59:58] == 2'h3 && MODULE_STATE[1:0] == 2'h1;
	endproperty
	a_timer: assert property (p_timer) else $error("fixed module state wrong");

	property p_hold;
		@(posedge CLK) disable iff (SYS_RST) CONFIG_VALID |=> $stable(BOOT_CONFIG_REGISTER)
			&& $stable(EXT_MEM_PIN_CONFIG);
	endproperty
	a_hold: assert property (p_hold) else $error("sampled straps changed");

	property p_valid_time;
		@(posedge CLK) $fell(SYS_RST) |-> ##5 CONFIG_VALID;
	endproperty
	a_valid_time: assert property (p_valid_time) else $error("defaults late");

	c_ext: cover property (@(posedge CLK) disable iff (SYS_RST) BOOT_FROM_EXT_MEM);
	c_uart: cover property (@(posedge CLK) disable iff (SYS_RST) CONFIG_VALID && BOOT_CONFIG_REGISTER == 2'h3);
	c_mmc: cover property (@(posedge CLK) disable iff (SYS_RST) CONFIG_VALID && BOOT_CONFIG_REGISTER == 2'h2);
	c_tw: cover property (@(posedge CLK) disable iff (SYS_RST) CONFIG_VALID && TIMING_WR);
endmodule : bsr_top

// ==== tb/bsr_strap_board.sv ====
`timescale 1ns/1ns
module bsr_strap_board (
	input wire logic clk, // Reference clock.
	input wire logic released, // Shared pins carry memory traffic.
	input wire logic [1:0] sel, // Boot code the board straps.
	input wire logic [3:0] cfg, // Pin config the board straps.
	output logic [1:0] sel_pins = 2'h0, // Boot-select pins.
	output logic [3:0] cfg_pins = 4'h0 // Pin-config pins.
);
	// Once released the pins carry bus traffic, shown as a pattern that flips every cycle.
	always @(posedge clk) begin
		if (released) begin
			{sel_pins, cfg_pins} <= ~{sel_pins, cfg_pins};
		end else begin
			{sel_pins, cfg_pins} <= {sel, cfg};
		end
	end
endmodule : bsr_strap_board

// ==== tb/tb_bsr_top.sv ====
`timescale 1ns/1ns
module tb_bsr_top;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] sel = 2'h0;
	logic [3:0] cfg = 4'h0;
	logic tim_wr = 1'b0;
	logic [4:0] tim_su = 5'h00;
	logic [6:0] tim_st = 7'h00;
	logic [3:0] tim_ho = 4'h0;
	logic [1:0] sel_pins;
	logic [3:0] cfg_pins;
	logic [81:0] mod_state;
	logic [40:0] pwr_on;
	logic [31:0] vector;
	logic from_ext;
	logic [1:0] boot_cfg;
	logic [3:0] pin_cfg;
	logic released;
	logic valid;
	logic [4:0] su;
	logic [6:0] st;
	logic [3:0] ho;
	int mismatches = 0;
	int checked = 0;
	always #20 clk = ~clk;
	bsr_strap_board i_bsr_strap_board (.clk(clk), .released(released), .sel(sel), .cfg(cfg),
		.sel_pins(sel_pins), .cfg_pins(cfg_pins));
	bsr_top i_bsr_top (.CLK(clk), .SYS_RST(sys_rst), .BOOT_SELECT_PINS(sel_pins),
		.EXT_MEM_PIN_CONFIG_STRAPS(cfg_pins), .TIMING_WR(tim_wr), .TIMING_SETUP_IN(tim_su),
		.TIMING_STROBE_IN(tim_st), .TIMING_HOLD_IN(tim_ho), .MODULE_STATE(mod_state),
		.MODULE_POWER_ON(pwr_on), .BOOT_VECTOR(vector), .BOOT_FROM_EXT_MEM(from_ext),
		.BOOT_CONFIG_REGISTER(boot_cfg), .EXT_MEM_PIN_CONFIG(pin_cfg), .STRAPS_RELEASED(released),
		.CONFIG_VALID(valid), .TIMING_SETUP(su), .TIMING_STROBE(st), .TIMING_HOLD(ho));
	task automatic chk(input logic bad, input string msg);
		checked++;
		if (bad) begin
			mismatches++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : chk
	function automatic logic [1:0] exp_ms(input int k, input logic [1:0] s);
		logic en;
		case (k)
			2, 3, 4, 14: en = (s != 2'h2);
			15: en = (s == 2'h2);
			19: en = (s == 2'h3);
			22: en = (s != 2'h1);
			27: en = 1'b1;
			16, 39: return bsr_pkg::BSR_MS_RSVD;
			default: en = (k >= 29 && k <= 38);
		endcase
		return en ? bsr_pkg::BSR_MS_ENABLE : bsr_pkg::BSR_MS_SYNC_RST;
	endfunction : exp_ms
	task automatic check_cfg(input logic [1:0] s, input logic [3:0] c);
		chk(boot_cfg !== s, "boot config");
		chk(pin_cfg !== c, "pin config");
		chk(released !== 1'b1, "pins not released");
		chk(vector !== ((s == 2'h1) ? 32'h02000000 : 32'h00008000), "boot vector");
		chk(from_ext !== (s == 2'h1), "external fetch");
		chk({su, st, ho} !== {5'h10, 7'h40, 4'h8}, "default timing");
		chk(pwr_on !== ~((41'h1 << 16) | (41'h1 << 39)), "power domains");
		for (int k = 0; k < 41; k++) begin
			chk(mod_state[2*k+:2] !== exp_ms(k, s), "module state");
		end
	endtask : check_cfg
	// Timing writes stay asserted through reset and sampling, where they must be ignored.
	task automatic reset_case(input logic [1:0] s, input logic [3:0] c);
		@(posedge clk);
		sys_rst <= 1'b1;
		sel <= s;
		cfg <= c;
		tim_wr <= 1'b1;
		{tim_su, tim_st, tim_ho} <= {5'h01, 7'h01, 4'h1};
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(released !== 1'b0, "pins released early");
		@(posedge clk);
		tim_wr <= 1'b0;
		@(negedge clk);
		chk(valid !== 1'b0, "valid early");
		@(negedge clk);
		chk(valid !== 1'b1, "valid late");
		@(negedge clk);
		check_cfg(s, c);
		repeat (8) @(negedge clk);
		check_cfg(s, c);
	endtask : reset_case
	task automatic timing_write;
		@(posedge clk);
		tim_wr <= 1'b1;
		{tim_su, tim_st, tim_ho} <= {5'h03, 7'h05, 4'h2};
		@(posedge clk);
		{tim_su, tim_st, tim_ho} <= {5'h1F, 7'h7F, 4'hF};
		@(negedge clk);
		chk({su, st, ho} !== {5'h03, 7'h05, 4'h2}, "first timing write");
		@(posedge clk);
		tim_wr <= 1'b0;
		@(negedge clk);
		chk({su, st, ho} !== {5'h1F, 7'h7F, 4'hF}, "second timing write");
	endtask : timing_write
	task stop_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test
	initial begin
		#200000;
		$display("FAIL %0t watchdog expired", $time);
		mismatches++;
		stop_test();
	end
	initial begin
		for (int i = 0; i < 4; i++) begin
			reset_case(i[1:0], {i[1:0], ~i[1:0]});
		end
		timing_write();
		reset_case(2'h1, 4'hD);
		stop_test();
	end
endmodule : tb_bsr_top
